// ==== ias_regs.vh ====
// Register map, field positions and constants of the address setup block
`ifndef IAS_REGS_VH
`define IAS_REGS_VH
// Byte offsets
`define IAS_OFF_CTL0 8'h00
`define IAS_OFF_CTL1 8'h04
`define IAS_OFF_SADDR0 8'h08
`define IAS_OFF_STAT 8'h18
`define IAS_OFF_STATC 8'h1c
`define IAS_ADDR_W 8
// Reset values
`define IAS_RST_WORD 32'h0000_0000
`define IAS_RST_ADDR 10'h000
// Control 0 fields
`define IAS_BIT_EN 0
// Control 1 fields
`define IAS_BIT_START 13
`define IAS_BIT_HEAD 12
`define IAS_BIT_WIDE 11
`define IAS_BIT_DIR 10
`define IAS_TA_HI 9
`define IAS_TA_LO 0
// Own address 0 fields
`define IAS_BIT_OAEN 15
`define IAS_BIT_OAFMT 10
`define IAS_OA_HI 9
`define IAS_OA_LO 0
// Status and status clear fields
`define IAS_BIT_SENT 3
// 10-bit header prefix
`define IAS_HDR10 5'h1e
// AHB encodings
`define IAS_HTRANS_NSEQ_BIT 1
`define IAS_HRESP_OKAY 1'b0
`endif

// ==== ias_addr_seq.v ====
// Master address sequencer: START, header and address bytes
`timescale 1ns/1ns
module ias_addr_seq (
   input wire hclk,
   input wire hresetn,
   input wire start_req,
   input wire abort,
   input wire wide,
   input wire dir,
   input wire head_only,
   input wire [9:0] target,
   input wire cond_done,
   input wire byte_done,
   output reg cond_req_r,
   output reg cond_rep_r,
   output reg [7:0] tx_byte_r,
   output reg tx_valid_r,
   output reg sent_r
);
`include "ias_regs.vh"
localparam S_IDLE = 3'd0;
localparam S_SCOND = 3'd1;
localparam S_B1 = 3'd2;
localparam S_B2 = 3'd3;
localparam S_RCOND = 3'd4;
localparam S_B3 = 3'd5;
localparam S_WAIT = 3'd6;
reg [2:0] st_r;
wire [7:0] hdr_w = {`IAS_HDR10, target[9:8], 1'b0};
wire [7:0] hdr_r = {`IAS_HDR10, target[9:8], 1'b1};
// Sequence walk; a request is served once and waits for its clear
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      st_r <= S_IDLE;
      cond_req_r <= 1'b0;
      cond_rep_r <= 1'b0;
      tx_byte_r <= 8'h00;
      tx_valid_r <= 1'b0;
      sent_r <= 1'b0;
   end else begin
      cond_req_r <= 1'b0;
      tx_valid_r <= 1'b0;
      sent_r <= 1'b0;
      if (abort) begin
         st_r <= S_IDLE;
      end else begin
         case (st_r)
            S_IDLE: begin
               if (start_req) begin
                  cond_req_r <= 1'b1;
                  // RULE_05 header only
                  if (wide && dir && head_only) begin
                     cond_rep_r <= 1'b1;
                     st_r <= S_RCOND;
                  end else begin
                     cond_rep_r <= 1'b0;
                     st_r <= S_SCOND;
                  end
               end
            end
            S_SCOND: begin
               if (cond_done) begin
                  tx_valid_r <= 1'b1;
                  // RULE_09 seven bit byte
                  if (!wide) tx_byte_r <= {target[7:1], dir};
                  else tx_byte_r <= hdr_w;
                  st_r <= S_B1;
               end
            end
            S_B1: begin
               if (byte_done) begin
                  if (!wide) begin
                     sent_r <= 1'b1;
                     st_r <= S_WAIT;
                  end else begin
                     // RULE_10 second address byte
                     tx_byte_r <= target[7:0];
                     tx_valid_r <= 1'b1;
                     st_r <= S_B2;
                  end
               end
            end
            S_B2: begin
               if (byte_done) begin
                  // RULE_04 restart then read
                  if (dir) begin
                     cond_req_r <= 1'b1;
                     cond_rep_r <= 1'b1;
                     st_r <= S_RCOND;
                  end else begin
                     sent_r <= 1'b1;
                     st_r <= S_WAIT;
                  end
               end
            end
            S_RCOND: begin
               if (cond_done) begin
                  tx_byte_r <= hdr_r;
                  tx_valid_r <= 1'b1;
                  st_r <= S_B3;
               end
            end
            S_B3: begin
               if (byte_done) begin
                  sent_r <= 1'b1;
                  st_r <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (!start_req) st_r <= S_IDLE;
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end
end
endmodule // ias_addr_seq

// ==== ias_own_match.v ====
// Own address 0 comparator for received address bytes
`timescale 1ns/1ns
module ias_own_match (
   input wire hclk,
   input wire hresetn,
   input wire oa_en,
   input wire oa_fmt,
   input wire [9:0] own_addr,
   input wire rx_valid,
   input wire [7:0] rx_first,
   input wire [7:0] rx_second,
   output reg match_r
);
`include "ias_regs.vh"
wire [9:0] rx_cat = {rx_first[2:1], rx_second};
wire [9:0] eq;
genvar i;
// Per bit equality against the stored address
generate
   for (i = 0; i < 10; i = i + 1) begin : g_eq
      assign eq[i] = ~(rx_cat[i] ^ own_addr[i]);
   end
endgenerate
wire hit7 = (rx_first[7:1] == own_addr[7:1]);
wire hit10 = (rx_first[7:3] == `IAS_HDR10) && (&eq);
// Match pulse, gated by enable and format
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      match_r <= 1'b0;
   end else begin
      // RULE_12 RULE_13 RULE_17 compare
      match_r <= rx_valid && oa_en && (oa_fmt ? hit10 : hit7);
   end
end
endmodule // ias_own_match

// ==== ias_top.v ====
// AHB-Lite register slave and master/slave address setup
// Overview of operation
// RULE_01 - Writing one to start requests START
// RULE_02 - Start cleared on sent, loss, timeout, disable
// RULE_03 - Address-sent clear write also drops start
// RULE_04 - Header-only 0: full ten bit read sequence
// RULE_05 - Header-only 1: restart plus read header
// RULE_06 - Header-only bit locked while start pending
// RULE_07 - Wide select picks seven or ten bits
// RULE_08 - Direction bit, locked while start pending
// RULE_09 - Seven bit uses target bits 7:1
// RULE_10 - Ten bit uses whole target field
// RULE_11 - Target field locked while start pending
// RULE_12 - Own address enable turns recognition on
// RULE_13 - Format bit picks seven or ten bits
// RULE_14 - Own address field layout as stored
// RULE_15 - Software leaves own address alone when enabled
// RULE_16 - Software keeps reserved bits at reset
// RULE_17 - Seven bit match uses own bits 7:1
`timescale 1ns/1ns
module ias_top (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata_r,
   output reg hreadyout_r,
   output reg hresp_r,
   input wire arb_lost,
   input wire timeout_evt,
   input wire cond_done,
   input wire byte_done,
   input wire rx_valid,
   input wire [7:0] rx_first,
   input wire [7:0] rx_second,
   output wire cond_req,
   output wire cond_rep,
   output wire [7:0] tx_byte,
   output wire tx_valid,
   output wire own_match,
   output reg peripheral_enable_r,
   output reg start_req_r,
   output reg master_direction_r,
   output reg master_wide_addressing_r,
   output reg addr_sent_flag_r
);
`include "ias_regs.vh"

// Address phase capture
reg wr_pend_r;
reg rd_pend_r;
reg [`IAS_ADDR_W-1:0] dp_addr_r;

// Control 1 fields
reg read_header_only_r;
reg [9:0] target_address_r;

// Own address 0 fields
reg own_addr0_enable_r;
reg own_addr0_format_r;
reg [9:0] own_addr0_r;

// Sequencer handshake
wire seq_sent;
wire seq_abort;

// Write strobes decoded in the data phase
wire acc;
wire wr_ctl0;
wire wr_ctl1;
wire wr_saddr0;
wire wr_statc;
wire sent_clr;
wire hw_start_clr;
wire start_set;

// Read mux
reg [31:0] rd_mux;

// Request is taken on NONSEQ or SEQ (htrans bit 1 high) with hsel and hready high
assign acc = hsel && hready && htrans[`IAS_HTRANS_NSEQ_BIT];

// Data phase write decodes
assign wr_ctl0 = wr_pend_r && (dp_addr_r == `IAS_OFF_CTL0);
assign wr_ctl1 = wr_pend_r && (dp_addr_r == `IAS_OFF_CTL1);
assign wr_saddr0 = wr_pend_r && (dp_addr_r == `IAS_OFF_SADDR0);
assign wr_statc = wr_pend_r && (dp_addr_r == `IAS_OFF_STATC);

// RULE_03 clear request bit
assign sent_clr = wr_statc && hwdata[`IAS_BIT_SENT];

// RULE_02 hardware clear sources
assign hw_start_clr = seq_sent || arb_lost || timeout_evt || sent_clr;

// RULE_01 software start set
assign start_set = wr_ctl1 && hwdata[`IAS_BIT_START] && peripheral_enable_r;

// Sequencer stops on loss, timeout, software clear or disable
assign seq_abort = arb_lost || timeout_evt || sent_clr || !peripheral_enable_r;

// Address phase latch and wait state for reads
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      dp_addr_r <= 8'h00;
      hreadyout_r <= 1'b1;
      hresp_r <= `IAS_HRESP_OKAY;
   end else begin
      hresp_r <= `IAS_HRESP_OKAY;
      if (acc) begin
         wr_pend_r <= hwrite;
         rd_pend_r <= !hwrite;
         dp_addr_r <= {haddr[`IAS_ADDR_W-1:2], 2'b00};
         hreadyout_r <= hwrite; // One wait state on reads
      end else if (hready) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         hreadyout_r <= 1'b1;
      end else begin
         hreadyout_r <= 1'b1;
      end
   end
end

// Read data assembled from live register state
always @* begin
   rd_mux = `IAS_RST_WORD;
   case (dp_addr_r)
      `IAS_OFF_CTL0: begin
         rd_mux[`IAS_BIT_EN] = peripheral_enable_r;
      end
      `IAS_OFF_CTL1: begin
         rd_mux[`IAS_BIT_START] = start_req_r;
         rd_mux[`IAS_BIT_HEAD] = read_header_only_r;
         rd_mux[`IAS_BIT_WIDE] = master_wide_addressing_r;
         rd_mux[`IAS_BIT_DIR] = master_direction_r;
         rd_mux[`IAS_TA_HI:`IAS_TA_LO] = target_address_r;
      end
      `IAS_OFF_SADDR0: begin
         // RULE_14 own address layout
         rd_mux[`IAS_BIT_OAEN] = own_addr0_enable_r;
         rd_mux[`IAS_BIT_OAFMT] = own_addr0_format_r;
         rd_mux[`IAS_OA_HI:`IAS_OA_LO] = own_addr0_r;
      end
      `IAS_OFF_STAT: begin
         rd_mux[`IAS_BIT_SENT] = addr_sent_flag_r;
      end
      default: begin
         rd_mux = `IAS_RST_WORD;
      end
   endcase
end

// Read data register, loaded during the wait cycle
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      hrdata_r <= `IAS_RST_WORD;
   end else if (rd_pend_r && !hreadyout_r) begin
      hrdata_r <= rd_mux;
   end
end

// Peripheral enable
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      peripheral_enable_r <= 1'b0;
   end else if (wr_ctl0) begin
      peripheral_enable_r <= hwdata[`IAS_BIT_EN];
   end
end

// Start request: set by software, cleared by hardware or by a status clear or disabling write
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      start_req_r <= 1'b0;
   end else if (!peripheral_enable_r || (wr_ctl0 && !hwdata[`IAS_BIT_EN])) begin
      // RULE_02 disable clears start, also on the disabling write itself
      start_req_r <= 1'b0;
   end else if (start_set) begin
      start_req_r <= 1'b1; // Set wins over a clear
   end else if (hw_start_clr) begin
      start_req_r <= 1'b0;
   end
end

// Master address fields, frozen while start is pending
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      read_header_only_r <= 1'b0;
      master_wide_addressing_r <= 1'b0;
      master_direction_r <= 1'b0;
      target_address_r <= `IAS_RST_ADDR;
   end else if (wr_ctl1 && !start_req_r) begin
      // RULE_06 header bit lock
      read_header_only_r <= hwdata[`IAS_BIT_HEAD];
      // RULE_07 wide select lock
      master_wide_addressing_r <= hwdata[`IAS_BIT_WIDE];
      // RULE_08 direction lock
      master_direction_r <= hwdata[`IAS_BIT_DIR];
      // RULE_11 target lock
      target_address_r <= hwdata[`IAS_TA_HI:`IAS_TA_LO];
   end
end

// Own address 0 register, reserved bits not stored
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      own_addr0_enable_r <= 1'b0;
      own_addr0_format_r <= 1'b0;
      own_addr0_r <= `IAS_RST_ADDR;
   end else if (wr_saddr0) begin
      // RULE_12 enable bit
      own_addr0_enable_r <= hwdata[`IAS_BIT_OAEN];
      // RULE_13 format bit
      own_addr0_format_r <= hwdata[`IAS_BIT_OAFMT];
      // RULE_14 address field
      own_addr0_r <= hwdata[`IAS_OA_HI:`IAS_OA_LO];
   end
end

// Address sent flag, the set wins over the clear
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      addr_sent_flag_r <= 1'b0;
   end else if (seq_sent) begin
      addr_sent_flag_r <= 1'b1;
   end else if (sent_clr || !peripheral_enable_r) begin
      addr_sent_flag_r <= 1'b0;
   end
end

// Master address sequencer
ias_addr_seq u_seq (
   .hclk(hclk),
   .hresetn(hresetn),
   .start_req(start_req_r),
   .abort(seq_abort),
   .wide(master_wide_addressing_r),
   .dir(master_direction_r),
   .head_only(read_header_only_r),
   .target(target_address_r),
   .cond_done(cond_done),
   .byte_done(byte_done),
   .cond_req_r(cond_req),
   .cond_rep_r(cond_rep),
   .tx_byte_r(tx_byte),
   .tx_valid_r(tx_valid),
   .sent_r(seq_sent)
);

// Own address comparator
ias_own_match u_match (
   .hclk(hclk),
   .hresetn(hresetn),
   .oa_en(own_addr0_enable_r && peripheral_enable_r),
   .oa_fmt(own_addr0_format_r),
   .own_addr(own_addr0_r),
   .rx_valid(rx_valid),
   .rx_first(rx_first),
   .rx_second(rx_second),
   .match_r(own_match)
);

endmodule // ias_top

// ==== ias_top_sva.sv ====
// Checker for the address setup block ports
`timescale 1ns/1ns
module ias_top_sva (
   input wire hclk,
   input wire hresetn,
   input wire arb_lost,
   input wire timeout_evt,
   input wire rx_valid,
   input wire cond_req,
   input wire cond_rep,
   input wire tx_valid,
   input wire [7:0] tx_byte,
   input wire own_match,
   input wire peripheral_enable_r,
   input wire start_req_r,
   input wire master_direction_r,
   input wire master_wide_addressing_r,
   input wire addr_sent_flag_r
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_start_then_cond: assert property ($rose(start_req_r) |=> cond_req) else $error("no START after request");
   a_start_needs_en: assert property (start_req_r |-> peripheral_enable_r) else $error("start while disabled");
   a_abort_clears: assert property ((arb_lost || timeout_evt) && start_req_r |=> !start_req_r)
      else $error("abort kept start");
   a_flag_drops_start: assert property ($rose(addr_sent_flag_r) |-> $fell(start_req_r)) else $error("flag without drop");
   a_fields_locked: assert property (start_req_r && $past(start_req_r) |->
      $stable(master_wide_addressing_r) && $stable(master_direction_r)) else $error("field changed");
   a_seven_dir_bit: assert property (tx_valid && !master_wide_addressing_r |-> tx_byte[0] == master_direction_r)
      else $error("direction bit wrong");
   a_restart_read: assert property (cond_req && cond_rep |-> master_wide_addressing_r && master_direction_r)
      else $error("restart outside wide read");
   a_match_after_rx: assert property (own_match |-> $past(rx_valid)) else $error("match without address");
endmodule // ias_top_sva
bind ias_top ias_top_sva u_sva (.hclk(hclk), .hresetn(hresetn), .arb_lost(arb_lost), .timeout_evt(timeout_evt),
   .rx_valid(rx_valid), .cond_req(cond_req), .cond_rep(cond_rep), .tx_valid(tx_valid), .tx_byte(tx_byte),
   .own_match(own_match), .peripheral_enable_r(peripheral_enable_r), .start_req_r(start_req_r),
   .master_direction_r(master_direction_r), .master_wide_addressing_r(master_wide_addressing_r),
   .addr_sent_flag_r(addr_sent_flag_r));

// ==== ias_link_model.sv ====
// Link engine model answering condition and byte requests
`timescale 1ns/1ns
module ias_link_model (
   input wire hclk,
   input wire hresetn,
   input wire cond_req,
   input wire tx_valid,
   input wire [2:0] dly,
   output logic cond_done,
   output logic byte_done
);
   logic [3:0] cc_r, bc_r;
   // Countdown per request, delay chosen by the bench
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cc_r <= 4'h0;
         bc_r <= 4'h0;
         cond_done <= 1'b0;
         byte_done <= 1'b0;
      end else begin
         cond_done <= (cc_r == 4'h1);
         byte_done <= (bc_r == 4'h1);
         cc_r <= cond_req ? {1'b0, dly} + 4'h1 : (cc_r != 4'h0 ? cc_r - 4'h1 : cc_r);
         bc_r <= tx_valid ? {1'b0, dly} + 4'h1 : (bc_r != 4'h0 ? bc_r - 4'h1 : bc_r);
      end
   end
endmodule // ias_link_model

// ==== ias_top_tb.sv ====
// Self-checking bench of the address setup block
`timescale 1ns/1ns
`include "ias_regs.vh"
module ias_top_tb;
   logic hclk, hresetn, hsel, hwrite, arb_lost, timeout_evt, rx_valid;
   logic [31:0] haddr, hwdata, rd, c1, oa;
   logic [1:0] htrans;
   logic [7:0] rx_first, rx_second;
   logic [2:0] dly;
   wire hready, cond_done, byte_done, cond_req, cond_rep, tx_valid, own_match, rdy, resp, pe, st, dir, wide, flag;
   wire [31:0] hrdata_r;
   wire [7:0] tx_byte;
   integer n_mismatch = 0, check_count = 0, i, j, t;
   logic [8:0] q_got[$], q_exp[$];
   assign hready = rdy;
   ias_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata_r(hrdata_r), .hreadyout_r(rdy), .hresp_r(resp),
      .arb_lost(arb_lost), .timeout_evt(timeout_evt), .cond_done(cond_done), .byte_done(byte_done),
      .rx_valid(rx_valid), .rx_first(rx_first), .rx_second(rx_second), .cond_req(cond_req), .cond_rep(cond_rep),
      .tx_byte(tx_byte), .tx_valid(tx_valid), .own_match(own_match), .peripheral_enable_r(pe), .start_req_r(st),
      .master_direction_r(dir), .master_wide_addressing_r(wide), .addr_sent_flag_r(flag));
   ias_link_model lm (.hclk(hclk), .hresetn(hresetn), .cond_req(cond_req), .tx_valid(tx_valid), .dly(dly),
      .cond_done(cond_done), .byte_done(byte_done));
   // Clock of 40 ns
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // Log of conditions and bytes sent to the link
   always @(posedge hclk) begin
      if (cond_req === 1'b1) q_got.push_back({8'h80, cond_rep});
      if (tx_valid === 1'b1) q_got.push_back({1'b0, tx_byte});
   end
   task print_verdict;
      if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Edge, then wait for hready high under a bound
   task wt;
      integer k;
      k = 0;
      @(posedge hclk);
      while (rdy !== 1'b1 && k < 50) begin
         @(posedge hclk);
         k++;
      end
      if (k >= 50) begin
         n_mismatch++;
         print_verdict;
      end
   endtask
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      wt;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt;
      rd = hrdata_r;
      chk(resp, `IAS_HRESP_OKAY);
   endtask
   // Expected link sequence for one control word
   task exp_q(input logic [31:0] c);
      q_exp = {};
      if (!c[11]) begin
         q_exp.push_back(9'h100);
         q_exp.push_back({1'b0, c[7:1], c[10]});
      end else begin
         if (!(c[10] && c[12])) begin
            q_exp.push_back(9'h100);
            q_exp.push_back({1'b0, 5'h1e, c[9:8], 1'b0});
            q_exp.push_back({1'b0, c[7:0]});
         end
         if (c[10]) begin
            q_exp.push_back(9'h101);
            q_exp.push_back({1'b0, 5'h1e, c[9:8], 1'b1});
         end
      end
   endtask
   function logic mt(input logic [31:0] o, input logic [7:0] f, input logic [7:0] s);
      mt = o[15] && (o[10] ? (f[7:3] == 5'h1e && f[2:1] == o[9:8] && s == o[7:0]) : f[7:1] == o[7:1]);
   endfunction
   // Main sequence
   initial begin
      {hresetn, hsel, hwrite, arb_lost, timeout_evt, rx_valid, haddr, hwdata, htrans, rx_first, rx_second} = 0;
      dly = 3'h0;
      oa = 32'h0000_0000;
      t = $urandom(45);
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1, `IAS_OFF_CTL1, 32'h0000_2000);
      @(posedge hclk);
      chk(st, 0);
      ahb(0, `IAS_OFF_SADDR0, 0);
      chk(rd, 0);
      ahb(0, 8'h20, 0);
      chk(rd, 0);
      ahb(1, `IAS_OFF_CTL0, 1);
      for (i = 0; i < 12; i++) begin
         c1 = $urandom & 32'h0000_1fff;
         if (i < 8) c1[12:10] = i[2:0];
         dly <= $urandom % 4;
         q_got = {};
         ahb(1, `IAS_OFF_CTL1, c1 | 32'h0000_2000);
         ahb(1, `IAS_OFF_CTL1, ~c1 & 32'h0000_1fff);
         t = 0;
         while (flag !== 1'b1 && t < 300) begin
            @(posedge hclk);
            t++;
         end
         if (t >= 300) begin
            n_mismatch++;
            print_verdict;
         end
         exp_q(c1);
         chk(q_got.size(), q_exp.size());
         for (j = 0; j < q_exp.size() && j < q_got.size(); j++) chk(q_got[j], q_exp[j]);
         ahb(0, `IAS_OFF_CTL1, 0);
         chk(rd, c1);
         chk({wide, dir}, c1[11:10]);
         ahb(0, `IAS_OFF_STAT, 0);
         chk(rd, 8);
         ahb(1, `IAS_OFF_STATC, 8);
      end
      for (j = 0; j < 4; j++) begin
         dly <= 3'h7;
         ahb(1, `IAS_OFF_CTL1, 32'h0000_2000);
         repeat (2) @(posedge hclk);
         if (j > 1) ahb(1, j == 2 ? `IAS_OFF_STATC : `IAS_OFF_CTL0, j == 2 ? 8 : 0);
         arb_lost <= (j == 0);
         timeout_evt <= (j == 1);
         @(posedge hclk);
         arb_lost <= (j == 2);
         timeout_evt <= 1'b0;
         @(posedge hclk);
         arb_lost <= 1'b0;
         chk(st, 0);
         chk(pe, j != 3);
         ahb(1, `IAS_OFF_CTL0, 1);
         repeat (12) @(posedge hclk);
      end
      for (i = 0; i < 16; i++) begin
         oa[15] = 1'b0;
         // Recognition off first, old fields kept
         ahb(1, `IAS_OFF_SADDR0, oa);
         oa = $urandom & 32'h0000_07ff;
         // Fields written while recognition is off
         ahb(1, `IAS_OFF_SADDR0, oa);
         oa[15] = (i != 0);
         ahb(1, `IAS_OFF_SADDR0, oa);
         ahb(0, `IAS_OFF_SADDR0, 0);
         chk(rd, oa);
         rx_first <= i[0] ? $urandom : (oa[10] ? {5'h1e, oa[9:8], 1'b0} : {oa[7:1], 1'b0});
         rx_second <= i[0] ? $urandom : oa[7:0];
         rx_valid <= 1'b1;
         @(posedge hclk);
         rx_valid <= 1'b0;
         @(posedge hclk);
         chk(own_match, mt(oa, rx_first, rx_second));
      end
      print_verdict;
   end
endmodule // ias_top_tb
